// ==== logic/aib_pkg.sv ====
// Purpose: Shared constants and types for the analog input bus decoder.
// Assumes: 50 MHz reference clock, byte registers on a 32-bit bus.
// Notes: Register indices are I/O offsets; byte address is four times.
`default_nettype none

package aib_pkg;

    localparam int CLK_PERIOD_NS = 20;
    localparam int IRQ_LOW_NS = 500;
    localparam int IRQ_LOW_CYC = (IRQ_LOW_NS + CLK_PERIOD_NS - 1)
        / CLK_PERIOD_NS;
    localparam int IRQ_HIGH_NS = 40;
    localparam int IRQ_HIGH_CYC = (IRQ_HIGH_NS + CLK_PERIOD_NS - 1)
        / CLK_PERIOD_NS;
    localparam int CNT_W = 5;

    // I/O address as seen on the word-addressed bus
    localparam int IO_LSB = 2;
    localparam int IO_AW = 10;
    localparam int SEL_W = 5;
    localparam int BASE_W = 5;
    localparam int EXT_BIT = 12;
    localparam logic [1:0] BASE_UPPER_NONE = 2'h0;

    localparam logic [4:0] REG_BOARD_STATUS = 5'h00;
    localparam logic [4:0] REG_IRQ_STATUS = 5'h01;
    localparam logic [4:0] REG_DATA_LO = 5'h02;
    localparam logic [4:0] REG_DATA_HI = 5'h03;

    // Event status and mask, outside the I/O window
    localparam logic [IO_AW-1:0] EXT_EVT_STAT = 10'h000;
    localparam logic [IO_AW-1:0] EXT_EVT_MASK = 10'h001;
    localparam int EVT_DONE_BIT = 0;
    localparam logic [7:0] EVT_RST = 8'h00;

    localparam int STAT_EOC_BIT = 7;
    localparam int STAT_BUSY_BIT = 6;
    localparam int STAT_GLB_BIT = 2;
    localparam int IRQ_ADC_BIT = 7;
    localparam int IRQ_GLB_BIT = 2;
    localparam logic [7:0] EN_RST = 8'h00;
    localparam logic [7:0] BYTE_ZERO = 8'h00;
    localparam int SIGN_BIT = 11;

    localparam int HTRANS_ACT_BIT = 1;
    localparam logic HRESP_OKAY = 1'b0;

    // Request lines 3-7, 9-12, 14 and 15
    localparam logic [15:0] IRQ_VALID_LINES = 16'hDEF8;

    typedef struct packed {
        logic [1:0] dev_mode;
        logic acq;
        logic range;
        logic bipolar;
        logic [2:0] chan;
    } aib_conv_cmd_t;

endpackage : aib_pkg

`default_nettype wire

// ==== logic/aib_irq_pulse.sv ====
// Purpose: Shareable interrupt pulse: low, brief high, then released.
// Assumes: fire_i is ignored while a pulse is in progress.
// Notes: Output enable high while the pin is driven.
`default_nettype none
`timescale 1ns/100ps

module aib_irq_pulse (
    input wire logic ref_clk_i,
    input wire logic reset_n_i,
    input wire logic fire_i,
    output logic line_o,
    output logic line_oe_o,
    output logic busy_o
);

    typedef enum logic [1:0] {PL_IDLE, PL_LOW, PL_HIGH} aib_pl_state_t;

    aib_pl_state_t state_ff;
    logic [aib_pkg::CNT_W-1:0] cnt_ff;

    always_ff @(posedge ref_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            state_ff <= PL_IDLE;
            cnt_ff <= '0;
        end
        else
        begin
            unique case (state_ff)
                PL_IDLE:
                begin
                    if (fire_i)
                    begin
                        state_ff <= PL_LOW;
                        cnt_ff <= aib_pkg::CNT_W'(aib_pkg::IRQ_LOW_CYC - 1);
                    end
                end
                PL_LOW:
                begin
                    if (cnt_ff == '0)
                    begin
                        state_ff <= PL_HIGH;
                        cnt_ff <= aib_pkg::CNT_W'(aib_pkg::IRQ_HIGH_CYC - 1);
                    end
                    else
                        cnt_ff <= cnt_ff - 1'b1;
                end
                PL_HIGH:
                begin
                    if (cnt_ff == '0)
                        state_ff <= PL_IDLE;
                    else
                        cnt_ff <= cnt_ff - 1'b1;
                end
            endcase
        end
    end

    assign line_o = (state_ff == PL_HIGH);
    assign line_oe_o = (state_ff != PL_IDLE);
    assign busy_o = (state_ff != PL_IDLE);

    // Length of the low drive, for checking only
    localparam int LOW_LEN = aib_pkg::IRQ_LOW_CYC;
    logic [7:0] low_run_ff;
    always_ff @(posedge ref_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
            low_run_ff <= 8'h00;
        else if (line_oe_o && !line_o)
            low_run_ff <= low_run_ff + 8'h01;
        else
            low_run_ff <= 8'h00;
    end

    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (!reset_n_i);

    AST_LOW_LENGTH: assert property (
        (line_oe_o && line_o && $past(line_oe_o) && !$past(line_o))
        |-> low_run_ff == 8'(LOW_LEN))
        else $error("interrupt low drive has wrong length");
    AST_HIGH_BEFORE_RELEASE: assert property (
        $fell(line_oe_o) |-> $past(line_o) ##0 !line_o [*2])
        else $error("interrupt released without a high drive");
    AST_FIRE_STARTS_LOW: assert property (
        (fire_i && !busy_o) |=> line_oe_o && !line_o [*3])
        else $error("interrupt pulse did not start low");

    COV_FULL_PULSE: cover property (
        $fell(line_oe_o));

endmodule : aib_irq_pulse

`default_nettype wire

// ==== logic/aib_bus_decoder.sv ====
// Purpose: Bus decoder, registers and interrupt of an 8-channel ADC board.
// Assumes: AHB-Lite slave, one wait state per transfer, word addressing.
// Notes: I/O address lines 9..0 sit at haddr 11..2.
// Function
// - Compare address lines nine to five with base jumpers, line five LSB.
// - Base bit reads one with jumper removed, zero with it fitted.
// - Only claim bases within 100h-3FFh; upper two bits zero never match.
// - Address lines four to zero pick a register inside the block.
// - Base and request line from jumpers; range chosen by software.
// - Interrupt may drive any of lines 3-7, 9-12, 14, 15.
// - Conversion end raises an interrupt or shows a pollable busy bit.
// - One written command carries channel, range and polarity together.
// - Four ranges: 0-5V, 0-10V, plus/minus 5V, plus/minus 10V.
// - Sustain starts up to 100k per second, one result each.
// - Each result is twelve bits from one of eight channels.
// - Four byte registers at offsets 00h to 03h.
// - Status EOC bit latches high, cleared by reading that register; IRQ pending and event bits clear on a write.
// - Shareable interrupt: low 500 ns, brief high, then released.
`default_nettype none
`timescale 1ns/100ps

module aib_bus_decoder (
    input wire logic ref_clk_i,
    input wire logic reset_n_i,
    input wire logic hsel_i,
    input wire logic [31:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic [2:0] hsize_i,
    input wire logic [31:0] hwdata_i,
    input wire logic hready_i,
    output logic [31:0] hrdata_o,
    output logic hreadyout_o,
    output logic hresp_o,
    input wire logic [4:0] base_jumper_fitted_i,
    input wire logic [3:0] irq_jumper_i,
    output var aib_pkg::aib_conv_cmd_t conv_cmd_o,
    output logic conv_start_o,
    input wire logic conv_done_i,
    input wire logic [11:0] conv_data_i,
    output logic [15:0] irq_line_o,
    output logic [15:0] irq_line_oe_o,
    output logic irq_o
);

    typedef enum logic [1:0] {PH_IDLE, PH_WAIT, PH_DONE} aib_phase_t;

    aib_phase_t phase_ff;
    logic [aib_pkg::IO_AW-1:0] a_io_ff;
    logic a_ext_ff;
    logic a_wr_ff;
    logic [31:0] rdata_ff;
    logic eoc_ff;
    logic busy_ff;
    logic irq_pend_ff;
    logic [7:0] en_ff;
    logic [7:0] evt_stat_ff;
    logic [7:0] evt_mask_ff;
    logic [11:0] data_ff;
    logic bipolar_ff;
    logic start_ff;
    aib_pkg::aib_conv_cmd_t cmd_ff;

    logic [aib_pkg::BASE_W-1:0] base_set;
    logic accept;
    logic hit;
    logic [aib_pkg::SEL_W-1:0] reg_sel;
    logic mapped;
    logic rd;
    logic wr;
    logic done_evt;
    logic start_ok;
    logic fire;
    logic pulse_line;
    logic pulse_oe;
    logic pulse_busy;
    logic [7:0] nxt_rbyte;
    logic [3:0] sign_ext;

    assign base_set = ~base_jumper_fitted_i;
    assign accept = hsel_i && htrans_i[aib_pkg::HTRANS_ACT_BIT] && hready_i;
    assign hit = !a_ext_ff
        && (base_set[4:3] != aib_pkg::BASE_UPPER_NONE)
        && (a_io_ff[9:5] == base_set);
    assign reg_sel = a_io_ff[4:0];
    assign mapped = hit && (reg_sel <= aib_pkg::REG_DATA_HI);
    assign rd = (phase_ff == PH_WAIT) && !a_wr_ff;
    assign wr = (phase_ff == PH_WAIT) && a_wr_ff;
    assign done_evt = conv_done_i && busy_ff;
    assign start_ok = wr && mapped && (reg_sel == aib_pkg::REG_DATA_LO)
        && !busy_ff;
    assign fire = done_evt && en_ff[aib_pkg::IRQ_ADC_BIT]
        && en_ff[aib_pkg::IRQ_GLB_BIT] && !irq_pend_ff && !pulse_busy;

    // Bus phase: one wait state so read data comes from a flop
    always_ff @(posedge ref_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
            phase_ff <= PH_IDLE;
        else if (phase_ff == PH_WAIT)
            phase_ff <= PH_DONE;
        else if (accept)
            phase_ff <= PH_WAIT;
        else
            phase_ff <= PH_IDLE;
    end

    always_ff @(posedge ref_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            a_io_ff <= '0;
            a_ext_ff <= 1'b0;
            a_wr_ff <= 1'b0;
        end
        else if (accept && phase_ff != PH_WAIT)
        begin
            a_io_ff <= haddr_i[aib_pkg::IO_LSB +: aib_pkg::IO_AW];
            a_ext_ff <= haddr_i[aib_pkg::EXT_BIT];
            a_wr_ff <= hwrite_i;
        end
    end

    assign hreadyout_o = (phase_ff != PH_WAIT);
    assign hresp_o = aib_pkg::HRESP_OKAY;

    // Read data mux
    assign sign_ext = bipolar_ff ? {4{data_ff[aib_pkg::SIGN_BIT]}} : 4'h0;
    always_comb
    begin
        nxt_rbyte = aib_pkg::BYTE_ZERO;
        if (a_ext_ff)
        begin
            if (a_io_ff == aib_pkg::EXT_EVT_STAT)
                nxt_rbyte = evt_stat_ff;
            else if (a_io_ff == aib_pkg::EXT_EVT_MASK)
                nxt_rbyte = evt_mask_ff;
        end
        else if (mapped)
        begin
            unique case (reg_sel)
                aib_pkg::REG_BOARD_STATUS:
                begin
                    nxt_rbyte[aib_pkg::STAT_EOC_BIT] = eoc_ff;
                    nxt_rbyte[aib_pkg::STAT_BUSY_BIT] = busy_ff;
                    nxt_rbyte[aib_pkg::STAT_GLB_BIT] =
                        en_ff[aib_pkg::IRQ_GLB_BIT];
                end
                aib_pkg::REG_IRQ_STATUS:
                begin
                    nxt_rbyte[aib_pkg::IRQ_ADC_BIT] = irq_pend_ff;
                    nxt_rbyte[aib_pkg::IRQ_GLB_BIT] = irq_pend_ff;
                end
                aib_pkg::REG_DATA_LO:
                    nxt_rbyte = data_ff[7:0];
                aib_pkg::REG_DATA_HI:
                    nxt_rbyte = {sign_ext, data_ff[11:8]};
                default:
                    nxt_rbyte = aib_pkg::BYTE_ZERO;
            endcase
        end
    end

    // Unmatched and upper offsets read as zero on this bus
    always_ff @(posedge ref_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
            rdata_ff <= '0;
        else if (rd)
            rdata_ff <= {24'h000000, nxt_rbyte};
    end
    assign hrdata_o = rdata_ff;

    // Latched conversion-done flag, read clears, set wins
    always_ff @(posedge ref_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
            eoc_ff <= 1'b0;
        else if (done_evt)
            eoc_ff <= 1'b1;
        else if (rd && mapped && reg_sel == aib_pkg::REG_BOARD_STATUS)
            eoc_ff <= 1'b0;
    end

    // Conversion command and busy tracking
    always_ff @(posedge ref_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            busy_ff <= 1'b0;
            start_ff <= 1'b0;
            cmd_ff <= '0;
        end
        else
        begin
            start_ff <= start_ok;
            if (start_ok)
            begin
                busy_ff <= 1'b1;
                cmd_ff <= aib_pkg::aib_conv_cmd_t'(hwdata_i[7:0]);
            end
            else if (done_evt)
                busy_ff <= 1'b0;
        end
    end
    assign conv_start_o = start_ff;
    assign conv_cmd_o = cmd_ff;

    always_ff @(posedge ref_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            data_ff <= '0;
            bipolar_ff <= 1'b0;
        end
        else if (done_evt)
        begin
            data_ff <= conv_data_i;
            bipolar_ff <= cmd_ff.bipolar;
        end
    end

    // Enables register; writes to upper offsets are dropped
    always_ff @(posedge ref_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
            en_ff <= aib_pkg::EN_RST;
        else if (wr && mapped && reg_sel == aib_pkg::REG_IRQ_STATUS)
            en_ff <= hwdata_i[7:0];
    end

    // Board interrupt pending until status write
    always_ff @(posedge ref_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
            irq_pend_ff <= 1'b0;
        else if (fire)
            irq_pend_ff <= 1'b1;
        else if (wr && mapped && reg_sel == aib_pkg::REG_BOARD_STATUS)
            irq_pend_ff <= 1'b0;
    end

    // Sticky event status, write one to clear, set wins
    always_ff @(posedge ref_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            evt_stat_ff <= aib_pkg::EVT_RST;
            evt_mask_ff <= aib_pkg::EVT_RST;
        end
        else
        begin
            if (wr && a_ext_ff && a_io_ff == aib_pkg::EXT_EVT_MASK)
                evt_mask_ff <= hwdata_i[7:0];
            if (wr && a_ext_ff && a_io_ff == aib_pkg::EXT_EVT_STAT)
                evt_stat_ff <= evt_stat_ff & ~hwdata_i[7:0];
            if (done_evt)
                evt_stat_ff[aib_pkg::EVT_DONE_BIT] <= 1'b1;
        end
    end
    assign irq_o = |(evt_stat_ff & evt_mask_ff);

    aib_irq_pulse u_irq_pulse (
        .ref_clk_i(ref_clk_i),
        .reset_n_i(reset_n_i),
        .fire_i(fire),
        .line_o(pulse_line),
        .line_oe_o(pulse_oe),
        .busy_o(pulse_busy)
    );

    // Route the pulse onto the jumper-selected request line
    genvar gi;
    generate
        for (gi = 0; gi < 16; gi++)
        begin : g_irq_line
            logic chosen;
            assign chosen = aib_pkg::IRQ_VALID_LINES[gi]
                && (irq_jumper_i == 4'(gi));
            assign irq_line_o[gi] = chosen && pulse_line;
            assign irq_line_oe_o[gi] = chosen && pulse_oe;
        end
    endgenerate

    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (!reset_n_i);

    AST_ONE_WAIT: assert property (
        (accept && phase_ff != PH_WAIT) |=> !hreadyout_o ##1 hreadyout_o)
        else $error("transfer did not take exactly one wait state");
    AST_UPPER_ZERO: assert property (
        (wr && !a_ext_ff && base_set[4:3] == aib_pkg::BASE_UPPER_NONE)
        |=> !conv_start_o && $stable(en_ff))
        else $error("block claimed a base with upper bits zero");
    AST_START_CMD: assert property (
        conv_start_o |-> busy_ff
        && conv_cmd_o == aib_pkg::aib_conv_cmd_t'($past(hwdata_i[7:0])))
        else $error("conversion command not taken as written");
    AST_EOC_SET: assert property (
        done_evt |=> eoc_ff && evt_stat_ff[aib_pkg::EVT_DONE_BIT])
        else $error("conversion done not latched");
    AST_EOC_READ_CLEAR: assert property (
        (rd && mapped && reg_sel == aib_pkg::REG_BOARD_STATUS && !done_evt)
        |=> !eoc_ff ##1 hrdata_o[aib_pkg::STAT_EOC_BIT] == $past(eoc_ff, 2))
        else $error("status read did not clear event");
    AST_UPPER_IGNORED: assert property (
        (wr && hit && reg_sel > aib_pkg::REG_DATA_HI && !fire)
        |=> $stable(en_ff) && !conv_start_o && $stable(irq_pend_ff))
        else $error("write to unused offset had an effect");
    AST_FIRE_GATED: assert property (
        $rose(|irq_line_oe_o) |-> $past(en_ff[aib_pkg::IRQ_GLB_BIT])
        && irq_pend_ff)
        else $error("interrupt driven without enable");
    AST_LINE_LEGAL: assert property (
        (irq_line_oe_o & ~aib_pkg::IRQ_VALID_LINES) == 16'h0000)
        else $error("interrupt driven on an unsupported line");
    AST_BUSY_POLL: assert property (
        start_ok |=> busy_ff ##1 (busy_ff || $past(conv_done_i)))
        else $error("busy not shown after start");

    COV_CONVERSION: cover property (
        conv_start_o ##[1:600] done_evt);
    COV_IRQ_PULSE: cover property (
        fire ##1 (|irq_line_oe_o));
    COV_STATUS_CLEAR: cover property (
        eoc_ff ##1 !eoc_ff);
    COV_EVT_IRQ: cover property (
        $rose(irq_o));

endmodule : aib_bus_decoder

`default_nettype wire

// ==== tb/aib_adc_model.sv ====
// Purpose: Converter stand-in answering start pulses with results.
// Assumes: One conversion at a time, done pulse delay_i+1 cycles after start.
// Notes: Result bus shows inverted data outside the done cycle.
`default_nettype none
`timescale 1ns/100ps

module aib_adc_model (
    input wire logic ref_clk_i,
    input wire logic reset_n_i,
    input wire logic start_i,
    input wire logic [7:0] delay_i,
    input wire logic [11:0] result_i,
    output logic done_o,
    output logic [11:0] data_o
);
    logic [7:0] cnt_ff;
    logic run_ff;

    always_ff @(posedge ref_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            run_ff <= 1'b0;
            cnt_ff <= 8'h00;
            done_o <= 1'b0;
        end
        else
        begin
            done_o <= 1'b0;
            if (start_i && !run_ff)
            begin
                run_ff <= 1'b1;
                cnt_ff <= delay_i;
            end
            else if (run_ff && cnt_ff == 8'h00)
            begin
                run_ff <= 1'b0;
                done_o <= 1'b1;
            end
            else if (run_ff)
                cnt_ff <= cnt_ff - 8'h01;
        end
    end

    // Inverted when idle so stale data never looks valid
    assign data_o = done_o ? result_i : ~result_i;
endmodule : aib_adc_model
`default_nettype wire

// ==== tb/analog_input_board_bus_decoder_tb.sv ====
// Purpose: Self-checking bench for the analog input bus decoder.
// Assumes: One slave on the bus, converter modelled.
// Notes: Reads are checked by a monitor from a queue of notes.
`default_nettype none
`timescale 1ns/100ps

module analog_input_board_bus_decoder_tb;
    logic clk, rst_n, hsel, hwrite, hrdy, hresp, cstart, cdone, irq;
    logic [1:0] htrans;
    logic [31:0] haddr, hwdata, hrdata;
    logic [4:0] jmp;
    logic [3:0] irqj;
    logic [11:0] res, cdata;
    logic [7:0] dly;
    logic [15:0] line, oe;
    aib_pkg::aib_conv_cmd_t cmd;
    logic [7:0] rdq[$];
    logic [7:0] cmdq[$];
    logic rd_ph = 1'b0;
    int mismatches = 0, checked = 0, starts = 0;
    int vl[11] = '{3, 4, 5, 6, 7, 9, 10, 11, 12, 14, 15};

    aib_bus_decoder DUT (
        .ref_clk_i(clk), .reset_n_i(rst_n), .hsel_i(hsel),
        .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite),
        .hsize_i(3'h2), .hwdata_i(hwdata), .hready_i(hrdy),
        .hrdata_o(hrdata), .hreadyout_o(hrdy), .hresp_o(hresp),
        .base_jumper_fitted_i(jmp), .irq_jumper_i(irqj),
        .conv_cmd_o(cmd), .conv_start_o(cstart),
        .conv_done_i(cdone), .conv_data_i(cdata),
        .irq_line_o(line), .irq_line_oe_o(oe), .irq_o(irq));

    aib_adc_model adc (.ref_clk_i(clk), .reset_n_i(rst_n),
        .start_i(cstart), .delay_i(dly), .result_i(res),
        .done_o(cdone), .data_o(cdata));

    initial
    begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    task automatic end_of_test;
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : end_of_test

    task automatic chk(input string nm, input logic [31:0] got,
        input logic [31:0] exp);
        checked++;
        if (got !== exp)
        begin
            mismatches++;
            $display("Error %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk

    task automatic edge_rdy;
        int n;
        n = 0;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (hrdy !== 1'b1 && n < 64);
        if (hrdy !== 1'b1)
        begin
            mismatches++;
            end_of_test();
        end
    endtask : edge_rdy

    task automatic bus(input logic w, input logic [31:0] a,
        input logic [7:0] d);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= w;
        edge_rdy();
        htrans <= 2'h0;
        hwdata <= {24'h000000, d};
        edge_rdy();
    endtask : bus

    task automatic wr(input logic [31:0] a, input logic [7:0] d);
        bus(1'b1, a, d);
    endtask : wr

    task automatic rd(input logic [31:0] a, input logic [7:0] e);
        rdq.push_back(e);
        bus(1'b0, a, 8'h00);
    endtask : rd

    // I/O line n sits at haddr bit n+2; base bit reads one when open
    function automatic logic [31:0] ra(input logic [4:0] o);
        ra = {20'h00000, ~jmp, o, 2'h0};
    endfunction : ra

    always @(posedge clk)
    begin
        if (rd_ph && hrdy)
            chk("hrdata", hrdata, {24'h0, rdq.pop_front()});
        if (cstart)
        begin
            starts++;
            chk("conv_cmd", {24'h0, cmd}, {24'h0, cmdq.pop_front()});
        end
        if (hrdy)
            rd_ph = hsel && htrans[1] && !hwrite;
    end

    initial
    begin
        int k, i, n;
        logic [7:0] c;
        rst_n = 1'b0;
        hsel = 1'b0;
        htrans = 2'h0;
        haddr = 32'h0;
        hwrite = 1'b0;
        hwdata = 32'h0;
        jmp = 5'h09;
        irqj = 4'h5;
        res = 12'h000;
        dly = 8'h28;
        k = $urandom(59);
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        chk("irq", 32'(irq), 32'h0);
        chk("oe", 32'(oe), 32'h0);
        rd(ra(5'h00), 8'h00);
        repeat (4)
        begin
            jmp <= 5'($urandom_range(0, 23));
            @(posedge clk);
            wr(ra(5'h01) ^ 32'h80, 8'h84);
            rd(ra(5'h00), 8'h00);
            wr(ra(5'h11), 8'h84);
            rd(ra(5'h13), 8'h00);
            rd(ra(5'h00), 8'h00);
            wr(ra(5'h01), 8'h84);
            rd(ra(5'h00), 8'h04);
            wr(ra(5'h01), 8'h00);
        end
        jmp <= 5'h1B;
        @(posedge clk);
        wr(ra(5'h01), 8'h84);
        jmp <= 5'h09;
        @(posedge clk);
        rd(ra(5'h00), 8'h00);
        wr(ra(5'h01), 8'h84);
        wr(32'h1004, 8'h01);
        for (k = 0; k < 4; k++)
        begin
            c = {3'h0, 2'(k), 3'($urandom_range(0, 7))};
            res <= 12'($urandom);
            irqj <= 4'(vl[$urandom_range(0, 10)]);
            cmdq.push_back(c);
            wr(ra(5'h02), c);
            wr(ra(5'h02), c ^ 8'h07);
            rd(ra(5'h00), 8'h44);
            n = 0;
            while (oe[irqj] !== 1'b1 && n < 100)
            begin
                @(posedge clk);
                n++;
            end
            if (n >= 100)
            begin
                mismatches++;
                end_of_test();
            end
            for (i = 0; i < 28; i++)
            begin
                chk("oe", 32'(oe), (i < 27) ? 32'h1 << irqj : 32'h0);
                if (i < 27)
                    chk("line", 32'(line[irqj]), 32'(i > 24));
                @(posedge clk);
            end
            chk("irq", 32'(irq), 32'h1);
            rd(ra(5'h00), 8'h84);
            rd(ra(5'h00), 8'h04);
            rd(ra(5'h01), 8'h84);
            rd(ra(5'h02), res[7:0]);
            rd(ra(5'h03), {k[0] ? {4{res[11]}} : 4'h0, res[11:8]});
            rd(32'h1000, 8'h01);
            wr(32'h1000, 8'h01);
            rd(32'h1000, 8'h00);
            chk("irq", 32'(irq), 32'h0);
            wr(ra(5'h00), 8'h00);
            rd(ra(5'h01), 8'h00);
        end
        wr(32'h1004, 8'h00);
        wr(ra(5'h01), 8'h00);
        cmdq.push_back(8'h00);
        wr(ra(5'h02), 8'h00);
        n = 0;
        while (cdone !== 1'b1 && n < 100)
        begin
            @(posedge clk);
            n++;
        end
        if (n >= 100)
        begin
            mismatches++;
            end_of_test();
        end
        repeat (30) @(posedge clk);
        chk("oe", 32'(oe), 32'h0);
        rd(32'h1000, 8'h01);
        chk("irq", 32'(irq), 32'h0);
        wr(32'h1004, 8'h01);
        rd(32'h1000, 8'h01);
        chk("irq", 32'(irq), 32'h1);
        wr(32'h1000, 8'h01);
        rd(ra(5'h00), 8'h80);
        // Reset in the middle of a conversion
        cmdq.push_back(8'h18);
        wr(ra(5'h02), 8'h18);
        rst_n <= 1'b0;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        chk("oe", 32'(oe), 32'h0);
        chk("irq", 32'(irq), 32'h0);
        rd(ra(5'h00), 8'h00);
        rd(32'h1000, 8'h00);
        chk("starts", 32'(starts), 32'h6);
        chk("hresp", 32'(hresp), 32'h0);
        end_of_test();
    end
endmodule : analog_input_board_bus_decoder_tb
`default_nettype wire
